// ### coproc_pkg.sv
// coproc_pkg: constants, types and the address map of the task dispatcher
// assumes: one system clock, synchronous active-high reset wherever a reset is used
package coproc_pkg;
  localparam int TASKS = 8;
  localparam int TASK_IDX_W = 3;
  localparam int PC_W = 12;
  localparam int AUX_W = 16;
  localparam int MR_W = 32;
  localparam int MR_NUM = 4;
  localparam int STF_W = 32;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 16;
  localparam int MSG_DEPTH = 128;
  localparam int MSG_IDX_W = 7;
  localparam int PIPE_STAGES = 8;
  // drain counter end: stop retires after the last pipeline stage
  localparam logic [2:0] DRAIN_LAST = 3'(PIPE_STAGES - 2);

  // main core view of the coprocessor, word addresses
  localparam logic [15:0] VECT_BASE = 16'h1400;
  localparam logic [15:0] PC_ADDR = 16'h1428;
  localparam logic [15:0] AUX0_ADDR = 16'h142A;
  localparam logic [15:0] AUX1_ADDR = 16'h142B;
  localparam logic [15:0] STF_ADDR = 16'h142E;
  localparam logic [15:0] MR_BASE = 16'h1430;
  localparam logic [15:0] TO_CORE_BASE = 16'h1480;
  localparam logic [15:0] TO_COP_BASE = 16'h1500;
  localparam int VECT_LSB = 3;
  localparam int MR_LSB = 4;
  localparam int MR_IDX_LSB = 2;
  localparam int MR_GAP_BIT = 1;
  localparam int MSG_LSB = 7;

  // status flag positions
  localparam int NEG_FLAG = 0;
  localparam int ZERO_FLAG = 1;
  // single-precision field positions
  localparam int FP_SIGN = 31;
  localparam int FP_EXP_HI = 30;
  localparam int FP_EXP_LO = 23;

  typedef enum logic [3:0] {
    OP_NOP, OP_STOP, OP_LOAD, OP_STORE, OP_LDAUX, OP_FNEG, OP_FABS, OP_BRANCH
  } op_t;

  typedef struct packed {
    op_t op;
    logic [1:0] mrSel;
    logic useAux;
    logic auxSel;
    logic [7:0] spare;
    logic [15:0] imm;
  } instr_t;

  typedef enum logic [1:0] {
    SRC_CONVERTER, SRC_PWM, SRC_ENCODER, SRC_CAPTURE
  } src_sel_t;

  typedef struct packed {
    logic [TASKS-1:0] converter;
    logic [TASKS-1:0] pwm;
    logic encoder;
    logic capture;
    logic timer0;
  } irq_src_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } core_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_RDWAIT, ST_LOAD, ST_DRAIN
  } state_t;
endpackage

// ### coprocessor_task_dispatch.sv
// coprocessor_task_dispatch: task dispatcher and small core of the
// floating-point control coprocessor, with message rams and debug view
// assumes: program memory answers the cycle after progFetch; data bus
// answers the cycle after dataRd; all inputs on the system clock
`timescale 1ns/1ps
`default_nettype none
module coprocessor_task_dispatch (
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire coproc_pkg::irq_src_t irqSrc, // peripheral interrupt levels
  input wire coproc_pkg::src_sel_t [coproc_pkg::TASKS-1:0] srcSel, // per task
  input wire logic coreAckTrig, // core acknowledge instruction pulse
  input wire logic [coproc_pkg::TASK_IDX_W-1:0] coreAckTask, // task chosen
  input wire logic progMapCoproc, // program memory given to coprocessor
  input wire logic dataMapCoproc, // data memory given to coprocessor
  input wire coproc_pkg::core_req_t coreReq, // core access request
  output logic [coproc_pkg::WORD_W-1:0] coreRdata, // core read data
  output logic coreRdValid, // core read data valid
  output logic [coproc_pkg::PC_W-1:0] progAddr, // program fetch address
  output logic progFetch, // program fetch strobe
  input wire logic [coproc_pkg::MR_W-1:0] progData, // fetched instruction
  output logic [coproc_pkg::ADDR_W-1:0] dataAddr, // data bus address
  output logic dataRd, // data bus read strobe
  output logic dataWr, // data bus write strobe
  output logic [coproc_pkg::MR_W-1:0] dataWdata, // data bus write data
  input wire logic [coproc_pkg::MR_W-1:0] dataRdata, // data bus read data
  output logic [coproc_pkg::TASKS-1:0] taskDoneIrq, // completion pulses
  output logic busy, // a task is running
  output logic [coproc_pkg::TASK_IDX_W-1:0] runTask // running task
);
  localparam int T = coproc_pkg::TASKS;

  coproc_pkg::state_t stateR;
  logic [T-1:0] trigVec, coreTrigVec, pendingR, pendingNxt, startMask;
  logic [coproc_pkg::TASK_IDX_W-1:0] nextTask, curTaskR;
  logic [coproc_pkg::PC_W-1:0] pcR;
  logic [coproc_pkg::PC_W-1:0] vectR [T];
  logic [coproc_pkg::MR_W-1:0] mrR [coproc_pkg::MR_NUM];
  logic [coproc_pkg::AUX_W-1:0] auxR [2];
  logic [coproc_pkg::STF_W-1:0] stfR;
  logic [2:0] drainR;
  logic [coproc_pkg::MR_W-1:0] mrSelVal;
  logic [1:0] loadMrR;
  logic msgHitR;
  logic startPulse;
  logic [T-1:0] taskDoneR;
  logic [coproc_pkg::ADDR_W-1:0] dataAddrR;
  logic [coproc_pkg::MR_W-1:0] dataWdataR;
  logic dataRdR, dataWrR;
  logic [coproc_pkg::WORD_W-1:0] coreRdataR;
  logic coreRdValidR;

  // per-task trigger selection; srcSel picks the source among lines fixed by the task number
  generate
    for (genvar g = 0; g < T; g++) begin : gTrig
      trigger_select #(.TASK_NUM(g + 1)) uTrig (
        .clock(clock),
        .rst(rst),
        .src(irqSrc),
        .sel(srcSel[g]),
        .trig(trigVec[g])
      );
    end
  endgenerate

  // core acknowledge decodes into a one-hot trigger
  assign coreTrigVec = coreAckTrig ? (T'(1) << coreAckTask) : '0;

  // lowest pending number wins
  always_comb begin
    nextTask = '0;
    for (int i = T - 1; i >= 0; i--) begin
      if (pendingR[i]) nextTask = coproc_pkg::TASK_IDX_W'(i);
    end
  end

  // a start happens only from idle, so a running task is never nested
  assign startPulse = (stateR == coproc_pkg::ST_IDLE) && (|pendingR) &&
                      progMapCoproc;
  assign startMask = startPulse ? (T'(1) << nextTask) : '0;
  // a trigger arriving as its task starts stays pending: set wins
  assign pendingNxt = (pendingR & ~startMask) | trigVec | coreTrigVec;

  always_ff @(posedge clock) begin
    if (rst) pendingR <= '0;
    else pendingR <= pendingNxt;
  end

  // instruction decode, all from the fetched word
  coproc_pkg::instr_t instr;
  logic [coproc_pkg::ADDR_W-1:0] effAddr;
  logic effToCore, effToCop, effExt;
  assign instr = coproc_pkg::instr_t'(progData);
  // pointer arithmetic wraps inside the 16-bit data space
  assign effAddr = instr.useAux ?
    coproc_pkg::ADDR_W'(auxR[instr.auxSel] + instr.imm) : instr.imm;
  assign effToCore = effAddr[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB] ==
    coproc_pkg::TO_CORE_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB];
  assign effToCop = effAddr[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB] ==
    coproc_pkg::TO_COP_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB];
  // rom and peripheral registers sit on the data bus; gated by mapping
  assign effExt = dataMapCoproc && !effToCore && !effToCop;
  assign mrSelVal = mrR[instr.mrSel];

  wire execOp = stateR == coproc_pkg::ST_EXEC;
  wire execStop = execOp && instr.op == coproc_pkg::OP_STOP;
  wire execStore = execOp && instr.op == coproc_pkg::OP_STORE;
  wire drainDone = (stateR == coproc_pkg::ST_DRAIN) &&
                   (drainR == coproc_pkg::DRAIN_LAST);

  // message rams: core-bound written by stores, coprocessor-bound by core
  logic [coproc_pkg::WORD_W-1:0] toCoreRd, toCopRd;
  logic coreHitToCore, coreHitToCop;
  assign coreHitToCore =
    coreReq.addr[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB] ==
    coproc_pkg::TO_CORE_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB];
  assign coreHitToCop =
    coreReq.addr[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB] ==
    coproc_pkg::TO_COP_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::MSG_LSB];

  message_ram #(
    .WIDTH(coproc_pkg::WORD_W), .DEPTH(coproc_pkg::MSG_DEPTH)
  ) uToCore (
    .clock(clock),
    .wrEn(execStore && effToCore),
    .wrIdx(effAddr[coproc_pkg::MSG_IDX_W-1:0]),
    .wrData(mrSelVal[coproc_pkg::WORD_W-1:0]),
    .rdIdx(coreReq.addr[coproc_pkg::MSG_IDX_W-1:0]),
    .rdData(toCoreRd)
  );

  message_ram #(
    .WIDTH(coproc_pkg::WORD_W), .DEPTH(coproc_pkg::MSG_DEPTH)
  ) uToCop (
    .clock(clock),
    .wrEn(coreReq.wr && coreHitToCop),
    .wrIdx(coreReq.addr[coproc_pkg::MSG_IDX_W-1:0]),
    .wrData(coreReq.wdata),
    .rdIdx(dataAddrR[coproc_pkg::MSG_IDX_W-1:0]),
    .rdData(toCopRd)
  );

  // loaded value; message words are zero-extended into a result register
  wire [coproc_pkg::MR_W-1:0] loadVal = msgHitR ?
    coproc_pkg::MR_W'(toCopRd) : dataRdata;
  wire [coproc_pkg::MR_W-1:0] negVal = mrSelVal ^
    (coproc_pkg::MR_W'(1) << coproc_pkg::FP_SIGN);
  wire [coproc_pkg::MR_W-1:0] absVal = mrSelVal &
    ~(coproc_pkg::MR_W'(1) << coproc_pkg::FP_SIGN);
  wire fpOp = execOp && (instr.op == coproc_pkg::OP_FNEG ||
                         instr.op == coproc_pkg::OP_FABS);
  wire [coproc_pkg::MR_W-1:0] fpVal =
    (instr.op == coproc_pkg::OP_FNEG) ? negVal : absVal;
  wire loadDone = stateR == coproc_pkg::ST_LOAD;
  wire [coproc_pkg::MR_W-1:0] flagSrc = loadDone ? loadVal : fpVal;

  // sequencer; only stop or reset ends a task
  always_ff @(posedge clock) begin
    if (rst) begin
      stateR <= coproc_pkg::ST_IDLE;
      curTaskR <= '0;
      pcR <= '0;
      drainR <= '0;
    end else begin
      case (stateR)
        coproc_pkg::ST_IDLE: begin
          if (startPulse) begin
            pcR <= vectR[nextTask];
            curTaskR <= nextTask;
            stateR <= coproc_pkg::ST_FETCH;
          end
        end
        coproc_pkg::ST_FETCH: stateR <= coproc_pkg::ST_EXEC;
        coproc_pkg::ST_EXEC: begin
          pcR <= coproc_pkg::PC_W'(pcR + coproc_pkg::PC_W'(1));
          stateR <= coproc_pkg::ST_FETCH;
          case (instr.op)
            coproc_pkg::OP_STOP: begin
              drainR <= '0;
              stateR <= coproc_pkg::ST_DRAIN;
            end
            coproc_pkg::OP_LOAD: stateR <= coproc_pkg::ST_RDWAIT;
            coproc_pkg::OP_BRANCH: pcR <= instr.imm[coproc_pkg::PC_W-1:0];
            default: ;
          endcase
        end
        coproc_pkg::ST_RDWAIT: stateR <= coproc_pkg::ST_LOAD;
        coproc_pkg::ST_LOAD: stateR <= coproc_pkg::ST_FETCH;
        coproc_pkg::ST_DRAIN: begin
          // the stop instruction walks out of the pipeline
          drainR <= 3'(drainR + 3'h1);
          if (drainDone) stateR <= coproc_pkg::ST_IDLE;
        end
        default: stateR <= coproc_pkg::ST_IDLE;
      endcase
    end
  end

  // completion pulse toward the interrupt expander
  always_ff @(posedge clock) begin
    if (rst) taskDoneR <= '0;
    else taskDoneR <= drainDone ? (T'(1) << curTaskR) : '0;
  end

  // data bus strobes registered from the executing instruction
  always_ff @(posedge clock) begin
    if (rst) begin
      dataAddrR <= '0;
      dataWdataR <= '0;
      dataRdR <= 1'b0;
      dataWrR <= 1'b0;
      msgHitR <= 1'b0;
      loadMrR <= '0;
    end else begin
      dataRdR <= execOp && instr.op == coproc_pkg::OP_LOAD && effExt;
      dataWrR <= execStore && effExt;
      if (execOp) begin
        dataAddrR <= effAddr;
        dataWdataR <= mrSelVal;
        msgHitR <= effToCop;
        loadMrR <= instr.mrSel;
      end
    end
  end

  // result, pointer and flag registers, written only by task code
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < coproc_pkg::MR_NUM; i++) mrR[i] <= '0;
      auxR[0] <= '0;
      auxR[1] <= '0;
      stfR <= '0;
    end else begin
      if (loadDone) mrR[loadMrR] <= loadVal;
      if (fpOp) mrR[instr.mrSel] <= fpVal;
      if (execOp && instr.op == coproc_pkg::OP_LDAUX)
        auxR[instr.auxSel] <= instr.imm;
      if (loadDone || fpOp) begin
        stfR[coproc_pkg::NEG_FLAG] <= flagSrc[coproc_pkg::FP_SIGN];
        stfR[coproc_pkg::ZERO_FLAG] <=
          ~|flagSrc[coproc_pkg::FP_EXP_HI:coproc_pkg::FP_EXP_LO];
      end
    end
  end

  // core access decode; debug registers take no writes at all
  wire coreHitVect = coreReq.addr[coproc_pkg::ADDR_W-1:coproc_pkg::VECT_LSB] ==
    coproc_pkg::VECT_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::VECT_LSB];
  wire coreHitMr = (coreReq.addr[coproc_pkg::ADDR_W-1:coproc_pkg::MR_LSB] ==
    coproc_pkg::MR_BASE[coproc_pkg::ADDR_W-1:coproc_pkg::MR_LSB]) &&
    !coreReq.addr[coproc_pkg::MR_GAP_BIT];
  wire coreHitStf = coreReq.addr[coproc_pkg::ADDR_W-1:1] ==
    coproc_pkg::STF_ADDR[coproc_pkg::ADDR_W-1:1];
  wire [1:0] coreMrIdx =
    coreReq.addr[coproc_pkg::MR_IDX_LSB+1:coproc_pkg::MR_IDX_LSB];
  wire [coproc_pkg::TASK_IDX_W-1:0] coreVectIdx =
    coreReq.addr[coproc_pkg::TASK_IDX_W-1:0];
  wire [coproc_pkg::MR_W-1:0] coreMrVal = mrR[coreMrIdx];
  // high word of a 32-bit register sits at the odd address
  wire [coproc_pkg::WORD_W-1:0] coreRdMux =
    coreHitVect ? coproc_pkg::WORD_W'(vectR[coreVectIdx]) :
    (coreReq.addr == coproc_pkg::PC_ADDR) ? coproc_pkg::WORD_W'(pcR) :
    (coreReq.addr == coproc_pkg::AUX0_ADDR) ? auxR[0] :
    (coreReq.addr == coproc_pkg::AUX1_ADDR) ? auxR[1] :
    coreHitStf ? (coreReq.addr[0] ? stfR[31:16] : stfR[15:0]) :
    coreHitMr ? (coreReq.addr[0] ? coreMrVal[31:16] : coreMrVal[15:0]) :
    coreHitToCore ? toCoreRd :
    coreHitToCop ? 16'h0000 : 16'h0000;

  // start vectors: with the coprocessor-bound message ram, the only coprocessor state the core may write
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < T; i++) vectR[i] <= '0;
    end else if (coreReq.wr && coreHitVect) begin
      vectR[coreVectIdx] <= coreReq.wdata[coproc_pkg::PC_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      coreRdataR <= '0;
      coreRdValidR <= 1'b0;
    end else begin
      coreRdValidR <= coreReq.rd;
      if (coreReq.rd) coreRdataR <= coreRdMux;
    end
  end

  // outputs; fetch handshake is combinational, data from flops
  assign progAddr = pcR;
  assign progFetch = stateR == coproc_pkg::ST_FETCH;
  assign dataAddr = dataAddrR;
  assign dataWdata = dataWdataR;
  assign dataRd = dataRdR;
  assign dataWr = dataWrR;
  assign taskDoneIrq = taskDoneR;
  assign busy = stateR != coproc_pkg::ST_IDLE;
  assign runTask = curTaskR;
  assign coreRdata = coreRdataR;
  assign coreRdValid = coreRdValidR;

  // checks; single clock domain so both stay in each property
  AST_VECT_LOAD: assert property (@(posedge clock) disable iff (rst)
    startPulse |=> pcR == $past(vectR[nextTask]))
    else $error("pc not loaded from start vector");
  AST_NO_NEST: assert property (@(posedge clock) disable iff (rst)
    busy && $past(busy) |-> curTaskR == $past(curTaskR) && !startPulse)
    else $error("task changed while running");
  AST_DONE_FLAG: assert property (@(posedge clock) disable iff (rst)
    execStop |-> ##8 taskDoneIrq == (T'(1) << $past(curTaskR, 8)))
    else $error("completion flag wrong or late");
  AST_AUTO_NEXT: assert property (@(posedge clock) disable iff (rst)
    (|taskDoneIrq) && (|pendingR) && progMapCoproc |-> startPulse)
    else $error("pending task not started after completion");
  AST_CORE_TRIG: assert property (@(posedge clock) disable iff (rst)
    coreAckTrig |=> pendingR[$past(coreAckTask)])
    else $error("core trigger not marked pending");
  AST_PRIORITY: assert property (@(posedge clock) disable iff (rst)
    startPulse |-> pendingR[nextTask] &&
      ((pendingR & ((T'(1) << nextTask) - T'(1))) == '0))
    else $error("started task is not the highest priority");
  AST_PEND_HOLD: assert property (@(posedge clock) disable iff (rst)
    ##1 (($past(pendingR) & ~pendingR & ~$past(startMask)) == '0))
    else $error("pending task dropped without start");
  AST_DEBUG_RO: assert property (@(posedge clock) disable iff (rst)
    !busy && !startPulse && coreReq.wr |=> pcR == $past(pcR) &&
      stfR == $past(stfR) &&
      auxR[0] == $past(auxR[0]))
    else $error("core write changed a debug register");
  AST_TRIG_PEND: assert property (@(posedge clock) disable iff (rst)
    trigVec[0] |=> pendingR[0])
    else $error("task 1 trigger lost");
endmodule
`default_nettype wire

// ### message_ram.sv
// message_ram: one-direction message buffer, one writer and one reader
// assumes: writer and reader on the same clock; read is asynchronous
`timescale 1ns/1ps
`default_nettype none
module message_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128
) (
  input wire logic clock, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] wrIdx, // write word index
  input wire logic [WIDTH-1:0] wrData, // write data
  input wire logic [$clog2(DEPTH)-1:0] rdIdx, // read word index
  output logic [WIDTH-1:0] rdData // read data
);
  logic [WIDTH-1:0] memR [DEPTH];

  // no reset: contents are undefined until written, as with real ram
  always_ff @(posedge clock) begin
    if (wrEn) memR[wrIdx] <= wrData;
  end
  assign rdData = memR[rdIdx];
endmodule
`default_nettype wire

// ### prog_mem_model.sv
// prog_mem_model: program memory and data bus seen from the coprocessor
// assumes: answers land one cycle after each strobe, same system clock
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input wire logic clock, // system clock
  input wire logic [coproc_pkg::PC_W-1:0] progAddr, // fetch address
  input wire logic progFetch, // fetch strobe
  output logic [coproc_pkg::MR_W-1:0] progData, // instruction word
  input wire logic dataRd, // data read strobe
  input wire logic [coproc_pkg::ADDR_W-1:0] dataAddr, // data address
  output logic [coproc_pkg::MR_W-1:0] dataRdata // data read word
);
  // a short program at 0x900, a stop everywhere else
  localparam logic [31:0] STOP_WORD = 32'h1000_0000;
  logic [31:0] fetchWord;
  always_comb begin
    case (progAddr)
      12'h900: fetchWord = 32'h2000_1500; // load result 0 from message 0
      12'h901: fetchWord = 32'h5000_0000; // negate result 0
      12'h902: fetchWord = 32'h3000_1480; // store to core-bound message 0
      12'h903: fetchWord = 32'h3000_0200; // store on the outer data bus
      default: fetchWord = STOP_WORD;
    endcase
  end
  initial progData = 32'h5A5A_5A5A;
  initial dataRdata = 32'hA5A5_A5A5;
  // toggle outside answers so stale words are never mistaken for data
  always @(posedge clock) begin
    progData <= progFetch ? fetchWord : ~progData;
    dataRdata <= dataRd ? {16'h0000, dataAddr} : ~dataRdata;
  end
endmodule
`default_nettype wire

// ### tb_coprocessor_task_dispatch.sv
// tb_coprocessor_task_dispatch: directed bench for the task dispatcher
// assumes: prog_mem_model stands in for program memory and data bus
`timescale 1ns/1ps
`default_nettype none
module tb_coprocessor_task_dispatch;
  logic clock, rst, coreAckTrig, progMapCoproc, dataMapCoproc;
  logic coreRdValid, progFetch, dataRd, dataWr, busy;
  coproc_pkg::irq_src_t irqSrc;
  coproc_pkg::src_sel_t [coproc_pkg::TASKS-1:0] srcSel;
  logic [2:0] coreAckTask, runTask;
  coproc_pkg::core_req_t coreReq;
  logic [15:0] coreRdata, dataAddr;
  logic [11:0] progAddr;
  logic [31:0] progData, dataWdata, dataRdata;
  logic [7:0] taskDoneIrq;
  int n_mismatch = 0;
  int n_checks = 0;

  coprocessor_task_dispatch dut (.clock(clock), .rst(rst),
    .irqSrc(irqSrc), .srcSel(srcSel), .coreAckTrig(coreAckTrig),
    .coreAckTask(coreAckTask), .progMapCoproc(progMapCoproc),
    .dataMapCoproc(dataMapCoproc), .coreReq(coreReq),
    .coreRdata(coreRdata), .coreRdValid(coreRdValid),
    .progAddr(progAddr), .progFetch(progFetch), .progData(progData),
    .dataAddr(dataAddr), .dataRd(dataRd), .dataWr(dataWr),
    .dataWdata(dataWdata), .dataRdata(dataRdata),
    .taskDoneIrq(taskDoneIrq), .busy(busy), .runTask(runTask));
  prog_mem_model mem (.clock(clock), .progAddr(progAddr),
    .progFetch(progFetch), .progData(progData), .dataRd(dataRd),
    .dataAddr(dataAddr), .dataRdata(dataRdata));

  always #4 clock = ~clock;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs change 1 ns after the edge, outputs are read there too
  task automatic cyc();
    @(posedge clock);
    #1;
  endtask

  function automatic logic [15:0] vec_of(input int k);
    return 16'((k + 1) * 256);
  endfunction

  task automatic core_wr(input logic [15:0] a, input logic [15:0] d);
    coreReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    cyc();
    coreReq = '0;
    cyc();
  endtask

  task automatic core_rd(input logic [15:0] a, input logic [15:0] exp);
    coreReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    cyc();
    check("rdValid", {15'h0000, coreRdValid}, 16'h0001);
    coreReq = '0;
    cyc();
    check("rdata", coreRdata, exp);
  endtask

  // follow one task from fetch to done; inj >= 0 acks task inj mid-run
  task automatic expect_task(input int k, input int inj);
    int n;
    int f;
    f = -1;
    if (inj >= 0) coreAckTask = 3'(inj);
    cyc();
    for (n = 0; n < 60 && taskDoneIrq === 8'h00; n++) begin
      if (inj >= 0) coreAckTrig = (f >= 0 && n == f + 2);
      if (progFetch === 1'b1 && f < 0) begin
        f = n;
        check("start", {4'h0, progAddr}, vec_of(k));
        check("busy", {15'h0000, busy}, 16'h0001);
      end
      cyc();
    end
    check("done", {8'h00, taskDoneIrq}, 16'(1 << k));
    check("runTask", {13'h0000, runTask}, 16'(k));
    check("stages", 16'(n - f), 16'h0009);
  endtask

  task automatic check_regs();
    core_rd(coproc_pkg::VECT_BASE, 16'h0000);
    for (int i = 0; i < 8; i++) core_wr(coproc_pkg::VECT_BASE + 16'(i), vec_of(i));
    for (int i = 0; i < 8; i++) core_rd(coproc_pkg::VECT_BASE + 16'(i), vec_of(i));
    core_wr(coproc_pkg::PC_ADDR, 16'h0ABC);
    core_rd(coproc_pkg::PC_ADDR, 16'h0000);
    core_wr(coproc_pkg::AUX0_ADDR, 16'h1234);
    core_rd(coproc_pkg::AUX0_ADDR, 16'h0000);
    core_rd(16'h1600, 16'h0000);
  endtask

  // trigger held pending while program memory belongs to the core
  task automatic map_gate();
    progMapCoproc = 1'b0;
    coreAckTask = 3'h3;
    coreAckTrig = 1'b1;
    cyc();
    coreAckTrig = 1'b0;
    repeat (20) begin
      cyc();
      check("idle", {15'h0000, busy}, 16'h0000);
    end
    progMapCoproc = 1'b1;
    expect_task(3, -1);
  endtask

  task automatic fire(input int k, input coproc_pkg::src_sel_t s);
    srcSel[k] = s;
    cyc();
    case (s)
      coproc_pkg::SRC_CONVERTER: irqSrc.converter[k] = 1'b1;
      coproc_pkg::SRC_PWM: if (k == 7) irqSrc.timer0 = 1'b1; else irqSrc.pwm[k] = 1'b1;
      coproc_pkg::SRC_ENCODER: irqSrc.encoder = 1'b1;
      default: irqSrc.capture = 1'b1;
    endcase
    cyc();
    irqSrc = '0;
    expect_task(k, -1);
    srcSel[k] = coproc_pkg::SRC_CONVERTER;
  endtask

  task automatic sources();
    for (int k = 0; k < 8; k++) begin
      fire(k, coproc_pkg::SRC_CONVERTER);
      fire(k, coproc_pkg::SRC_PWM);
    end
    for (int k = 3; k < 8; k++) begin
      if (k == 4 || k == 5) continue;
      fire(k, coproc_pkg::SRC_ENCODER);
      fire(k, coproc_pkg::SRC_CAPTURE);
    end
  endtask

  // two at once, then a top-priority ack arriving mid-task
  task automatic no_nesting();
    irqSrc.converter[5] = 1'b1;
    irqSrc.converter[2] = 1'b1;
    cyc();
    irqSrc = '0;
    expect_task(2, 0);
    expect_task(0, -1);
    expect_task(5, -1);
  endtask

  // program run: message load, negate, two stores; dmap gates the outer bus
  task automatic run_prog(input logic dmap);
    int n;
    logic wr;
    logic [15:0] a;
    logic [15:0] w;
    logic [31:0] d;
    wr = 1'b0;
    a = 16'h0000;
    d = 32'h0000_0000;
    w = dmap ? 16'hC123 : 16'h4567;
    dataMapCoproc = dmap;
    core_wr(coproc_pkg::TO_COP_BASE, w);
    core_wr(coproc_pkg::VECT_BASE, 16'h0900);
    coreAckTask = 3'h0;
    coreAckTrig = 1'b1;
    cyc();
    coreAckTrig = 1'b0;
    for (n = 0; n < 40 && taskDoneIrq === 8'h00; n++) begin
      if (dataWr === 1'b1) begin
        wr = 1'b1;
        a = dataAddr;
        d = dataWdata;
      end
      cyc();
    end
    check("done", {8'h00, taskDoneIrq}, 16'h0001);
    check("dataWr", {15'h0000, wr}, {15'h0000, dmap});
    if (dmap) begin
      check("dataAddr", a, 16'h0200);
      check("wdataHi", d[31:16], 16'h8000);
      check("wdataLo", d[15:0], w);
    end
    core_rd(coproc_pkg::TO_CORE_BASE, w);
    core_rd(coproc_pkg::MR_BASE + 16'h0001, 16'h8000);
    core_rd(coproc_pkg::MR_BASE, w);
    core_rd(coproc_pkg::STF_ADDR, 16'h0003);
    dataMapCoproc = 1'b1;
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    irqSrc = '0;
    coreAckTrig = 1'b0;
    coreAckTask = 3'h0;
    progMapCoproc = 1'b1;
    dataMapCoproc = 1'b1;
    coreReq = '0;
    for (int i = 0; i < 8; i++) srcSel[i] = coproc_pkg::SRC_CONVERTER;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    check_regs();
    map_gate();
    sources();
    no_nesting();
    run_prog(1'b1);
    run_prog(1'b0);
    end_sim();
  end

  // the whole run needs some five hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire

// ### trigger_select.sv
// trigger_select: picks one task's trigger source and turns it into a pulse
// assumes: interrupt sources are levels on the same clock, no synchroniser
`timescale 1ns/1ps
`default_nettype none
module trigger_select #(
  parameter int TASK_NUM = 1
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset
  input wire coproc_pkg::irq_src_t src, // peripheral interrupt levels
  input wire coproc_pkg::src_sel_t sel, // configured source
  output logic trig // one-cycle trigger pulse
);
  // only tasks 4, 7, 8 take encoder and capture
  localparam bit EXT_OK = (TASK_NUM == 4) || (TASK_NUM == 7) ||
                          (TASK_NUM == coproc_pkg::TASKS);
  localparam bit USE_TIMER = (TASK_NUM == coproc_pkg::TASKS);

  logic convLevel;
  logic secondLevel;
  logic selLevel;
  logic prevR;

  // task 8 takes timer 0 where others take their pwm line
  assign convLevel = src.converter[TASK_NUM-1];
  assign secondLevel = USE_TIMER ? src.timer0 : src.pwm[TASK_NUM-1];
  assign selLevel =
    (sel == coproc_pkg::SRC_CONVERTER) ? convLevel :
    (sel == coproc_pkg::SRC_PWM) ? secondLevel :
    (EXT_OK && sel == coproc_pkg::SRC_ENCODER) ? src.encoder :
    (EXT_OK && sel == coproc_pkg::SRC_CAPTURE) ? src.capture : 1'b0;

  // rising edge only, so a held level triggers once
  always_ff @(posedge clock) begin
    if (rst) prevR <= 1'b0;
    else prevR <= selLevel;
  end
  assign trig = selLevel & ~prevR;
endmodule
`default_nettype wire
